// ===== common/lpm_consts.svh
// Offsets, field positions, reset values and timing of the power controller
// Assumes a 32-bit AXI4-Lite bus with byte addresses and a 125 MHz clock
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH
`define LPM_OFS_POWER_CONTROL_ZERO 8'h00
`define LPM_OFS_PCON1 8'h04
`define LPM_OFS_STAT 8'h08
`define LPM_P0_SLEEP 0
`define LPM_P0_HOLD 1
`define LPM_P0_IDLE 2
`define LPM_P0_DEEP 3
`define LPM_P0_SYSDIS 4
`define LPM_P0_IRAMDIS 5
`define LPM_P0_DRAMDIS 6
`define LPM_P1_SDPG 4
`define LPM_P1_BATT 5
`define LPM_RST_P0 8'h00
`define LPM_RST_P1 8'h00
`define LPM_RESP_OK 2'h0
`define LPM_RESP_ERR 2'h2
`define LPM_CLK_NS 8
`define LPM_RST_NS 64
`define LPM_RST_CYC ((`LPM_RST_NS + `LPM_CLK_NS - 1) / `LPM_CLK_NS)
`endif

// ===== common/lpm_pkg.sv
// Types of the power controller: modes, wake actions, causes, state
// Assumes lpm_consts.svh for all numbers
package lpm_pkg;
   typedef enum logic [2:0] {
      LPM_RUN = 3'b000,
      LPM_SLEEP = 3'b001,
      LPM_HOLD = 3'b010,
      LPM_IDLE = 3'b011,
      LPM_DEEP = 3'b100
   } lpm_mode_t;
   typedef enum logic [1:0] {
      LPM_STAY = 2'b00,
      LPM_RESUME = 2'b01,
      LPM_ISR = 2'b10,
      LPM_RESET = 2'b11
   } lpm_act_t;
   typedef enum logic [2:0] {
      LPM_C_NONE = 3'b000,
      LPM_C_PORT = 3'b001,
      LPM_C_RTC = 3'b010,
      LPM_C_WDT = 3'b011,
      LPM_C_RST = 3'b100,
      LPM_C_IRQ = 3'b101
   } lpm_cause_t;
   typedef struct packed {
      logic awRdy, wRdy, arRdy, awDone, wDone, wStrb0;
      logic [7:0] awAddr;
      logic [7:0] wData;
      logic bValid, rValid;
      logic [1:0] bResp;
      logic [1:0] rResp;
      logic [7:0] rData;
      lpm_mode_t mode;
      lpm_cause_t cause;
      logic [7:0] power_control_zero;
      logic [7:0] pcon1;
      logic [3:0] rstCnt;
      logic sysClkEn, cpuClkEn, srcClkEn, memCsEn, dramClkEn, iramClkEn;
      logic chipRst, isrReq, resume, deep;
   } lpm_state_t;
endpackage

// ===== common/lpm_wake_if.sv
// Wake events, enables and the resulting action between controller parts
// Assumes the controller drives events and mode, evaluator answers
`timescale 1ns/1ps
`default_nettype none
interface lpm_wake_if;
   lpm_pkg::lpm_mode_t mode;
   logic portEvt, rtcEvt, wdtEvt, rstEvt, irqEvt;
   logic portIntEn, rtcIntEn, wdtIntEn, wdtRstEn, globalIntEn;
   lpm_pkg::lpm_act_t act;
   lpm_pkg::lpm_cause_t cause;
   modport ctrl (
      output mode, portEvt, rtcEvt, wdtEvt, rstEvt, irqEvt,
      output portIntEn, rtcIntEn, wdtIntEn, wdtRstEn, globalIntEn,
      input act, cause
   );
   modport eval (
      input mode, portEvt, rtcEvt, wdtEvt, rstEvt, irqEvt,
      input portIntEn, rtcIntEn, wdtIntEn, wdtRstEn, globalIntEn,
      output act, cause
   );
endinterface
`default_nettype wire

// ===== design/lpm_ctrl.sv
// Low-power mode controller with its AXI4-Lite register slave
// Assumes one 125 MHz clock, synchronous reset, events synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
`include "lpm_consts.svh"
module lpm_ctrl (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Wake and interrupt events
   input wire logic portWake,
   input wire logic rtcWake,
   input wire logic wdtWake,
   input wire logic resetEvent,
   input wire logic anyIrq,
   // Interrupt and watchdog enables from the core
   input wire logic portIntEn,
   input wire logic rtcIntEn,
   input wire logic wdtIntEn,
   input wire logic wdtResetEn,
   input wire logic globalIntEn,
   // Clock gates and chip selects
   output logic sysClkEn,
   output logic cpuClkEn,
   output logic clkSrcEn,
   output logic memCsEn,
   output logic decoderRamClkEn,
   output logic internalRamClkEn,
   // Wake actions towards core and reset logic
   output logic chipReset,
   output logic isrRequest,
   output logic [2:0] isrCause,
   output logic resumeNext,
   // Mode state
   output logic [2:0] modeState,
   output logic deepSleep,
   // Power switches
   output logic batteryOutEn,
   output logic sdPowerGateEn
);
   lpm_pkg::lpm_state_t q;
   lpm_pkg::lpm_state_t d;
   lpm_pkg::lpm_mode_t nextMode;
   logic exitNow;
   lpm_wake_if wk ();

   // Events and enables towards the wake evaluator
   assign wk.mode = q.mode;
   assign wk.portEvt = portWake;
   assign wk.rtcEvt = rtcWake;
   assign wk.wdtEvt = wdtWake;
   assign wk.rstEvt = resetEvent;
   assign wk.irqEvt = anyIrq;
   assign wk.portIntEn = portIntEn;
   assign wk.rtcIntEn = rtcIntEn;
   assign wk.wdtIntEn = wdtIntEn;
   assign wk.wdtRstEn = wdtResetEn;
   assign wk.globalIntEn = globalIntEn;

   // Wake decision for the current mode
   lpm_wake_eval wakeEval (
      .w (wk)
   );

   // Entry choice from the request bits: sleep first, then deep, hold, idle
   always_comb begin
      nextMode = lpm_pkg::LPM_RUN;
      if (q.power_control_zero[`LPM_P0_SLEEP]) begin
         nextMode = lpm_pkg::LPM_SLEEP;
      end else if (q.power_control_zero[`LPM_P0_DEEP]) begin
         nextMode = lpm_pkg::LPM_DEEP;
      end else if (q.power_control_zero[`LPM_P0_HOLD]) begin
         nextMode = lpm_pkg::LPM_HOLD;
      end else if (q.power_control_zero[`LPM_P0_IDLE]) begin
         nextMode = lpm_pkg::LPM_IDLE;
      end
   end

   assign exitNow = (wk.act != lpm_pkg::LPM_STAY);

   // Next state of the whole controller
   always_comb begin
      d = q;
      d.isrReq = 1'b0;
      d.resume = 1'b0;

      // Reset pulse towards the chip reset logic
      if (q.rstCnt != 4'h0) begin
         d.rstCnt = q.rstCnt - 4'h1;
      end

      // Mode machine
      unique case (q.mode)
         lpm_pkg::LPM_RUN: begin
            d.mode = nextMode;
            if (nextMode == lpm_pkg::LPM_SLEEP) begin
               d.power_control_zero[`LPM_P0_SYSDIS] = 1'b0;
               d.power_control_zero[`LPM_P0_IRAMDIS] = 1'b0;
               d.power_control_zero[`LPM_P0_DRAMDIS] = 1'b0;
            end
         end
         lpm_pkg::LPM_SLEEP,
         lpm_pkg::LPM_DEEP,
         lpm_pkg::LPM_HOLD,
         lpm_pkg::LPM_IDLE: begin
            if (exitNow) begin
               d.mode = lpm_pkg::LPM_RUN;
               d.cause = wk.cause;
               d.power_control_zero[`LPM_P0_SLEEP] = 1'b0;
               d.power_control_zero[`LPM_P0_DEEP] = 1'b0;
               d.power_control_zero[`LPM_P0_HOLD] = 1'b0;
               d.power_control_zero[`LPM_P0_IDLE] = 1'b0;
               unique case (wk.act)
                  lpm_pkg::LPM_RESET: begin
                     d.rstCnt = 4'(`LPM_RST_CYC);
                  end
                  lpm_pkg::LPM_ISR: begin
                     d.isrReq = 1'b1;
                  end
                  lpm_pkg::LPM_RESUME: begin
                     d.resume = 1'b1;
                  end
                  lpm_pkg::LPM_STAY: begin
                     d.resume = 1'b0;
                  end
               endcase
            end
         end
         default: begin
            d.mode = lpm_pkg::LPM_RUN;
         end
      endcase

      // Write address and data are taken in either order
      if (s_axi_awvalid && q.awRdy) begin
         d.awDone = 1'b1;
         d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wRdy) begin
         d.wDone = 1'b1;
         d.wData = s_axi_wdata[7:0];
         d.wStrb0 = s_axi_wstrb[0];
      end

      // Response accepted by the master
      if (q.bValid && s_axi_bready) begin
         d.bValid = 1'b0;
      end

      // Commit once both halves are held; a write after the exit clear
      // wins, so a new request in the same cycle is kept
      if (q.awDone && q.wDone) begin
         d.awDone = 1'b0;
         d.wDone = 1'b0;
         d.bValid = 1'b1;
         d.bResp = `LPM_RESP_OK;
         unique case ({q.awAddr[7:2], 2'b00})
            `LPM_OFS_POWER_CONTROL_ZERO: begin
               if (q.wStrb0) begin
                  d.power_control_zero = q.wData;
               end
            end
            `LPM_OFS_PCON1: begin
               if (q.wStrb0) begin
                  d.pcon1 = q.wData;
               end
            end
            default: begin
               d.bResp = `LPM_RESP_ERR;
            end
         endcase
      end

      // Read answer follows one cycle after the address
      if (q.rValid && s_axi_rready) begin
         d.rValid = 1'b0;
      end
      if (s_axi_arvalid && q.arRdy) begin
         d.rValid = 1'b1;
         d.rResp = `LPM_RESP_OK;
         unique case ({s_axi_araddr[7:2], 2'b00})
            `LPM_OFS_POWER_CONTROL_ZERO: begin
               d.rData = q.power_control_zero;
            end
            `LPM_OFS_PCON1: begin
               d.rData = q.pcon1;
            end
            `LPM_OFS_STAT: begin
               d.rData = {1'b0, q.cause, 1'b0, q.mode};
            end
            default: begin
               d.rData = 8'h00;
               d.rResp = `LPM_RESP_ERR;
            end
         endcase
      end

      // Ready flags registered from the next state
      d.awRdy = !d.awDone && !d.bValid;
      d.wRdy = !d.wDone && !d.bValid;
      d.arRdy = !d.rValid;

      // Clock gates and selects from the next mode and next disable bits
      d.srcClkEn = !(d.mode == lpm_pkg::LPM_SLEEP ||
         d.mode == lpm_pkg::LPM_DEEP);
      d.memCsEn = d.srcClkEn;
      d.sysClkEn = d.srcClkEn && (d.mode != lpm_pkg::LPM_HOLD) &&
         !d.power_control_zero[`LPM_P0_SYSDIS];
      d.cpuClkEn = d.sysClkEn && (d.mode != lpm_pkg::LPM_IDLE);
      d.dramClkEn = !d.power_control_zero[`LPM_P0_DRAMDIS];
      d.iramClkEn = !d.power_control_zero[`LPM_P0_IRAMDIS];
      d.chipRst = (d.rstCnt != 4'h0);
      d.deep = (d.mode == lpm_pkg::LPM_DEEP);
   end

   // State register
   always_ff @(posedge mclk) begin
      if (srst) begin
         q <= '0;
         q.awRdy <= 1'b1;
         q.wRdy <= 1'b1;
         q.arRdy <= 1'b1;
         q.mode <= lpm_pkg::LPM_RUN;
         q.cause <= lpm_pkg::LPM_C_NONE;
         q.power_control_zero <= `LPM_RST_P0;
         q.pcon1 <= `LPM_RST_P1;
         q.sysClkEn <= 1'b1;
         q.cpuClkEn <= 1'b1;
         q.srcClkEn <= 1'b1;
         q.memCsEn <= 1'b1;
         q.dramClkEn <= 1'b1;
         q.iramClkEn <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Bus outputs
   assign s_axi_awready = q.awRdy;
   assign s_axi_wready = q.wRdy;
   assign s_axi_bvalid = q.bValid;
   assign s_axi_bresp = q.bResp;
   assign s_axi_arready = q.arRdy;
   assign s_axi_rvalid = q.rValid;
   assign s_axi_rresp = q.rResp;
   assign s_axi_rdata = {24'h00_0000, q.rData};

   // Clock gates
   assign sysClkEn = q.sysClkEn;
   assign cpuClkEn = q.cpuClkEn;
   assign clkSrcEn = q.srcClkEn;
   assign memCsEn = q.memCsEn;
   assign decoderRamClkEn = q.dramClkEn;
   assign internalRamClkEn = q.iramClkEn;

   // Wake actions
   assign chipReset = q.chipRst;
   assign isrRequest = q.isrReq;
   assign isrCause = q.cause;
   assign resumeNext = q.resume;

   // Mode and power switches
   assign modeState = q.mode;
   assign deepSleep = q.deep;
   assign batteryOutEn = q.pcon1[`LPM_P1_BATT];
   assign sdPowerGateEn = q.pcon1[`LPM_P1_SDPG];
endmodule // lpm_ctrl
`default_nettype wire

// ===== design/lpm_wake_eval.sv
// Decides how each low-power mode ends for the events of this cycle
// Assumes events are single-cycle or level requests synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module lpm_wake_eval (
   // Events and mode in, action out
   lpm_wake_if.eval w
);
   // Mode-dependent wake decision, reset events first in hold and idle
   always_comb begin
      w.act = lpm_pkg::LPM_STAY;
      w.cause = lpm_pkg::LPM_C_NONE;
      unique case (w.mode)
         lpm_pkg::LPM_SLEEP: begin
            if (w.portEvt || w.wdtEvt || w.rtcEvt) begin
               w.act = lpm_pkg::LPM_RESET;
               w.cause = w.wdtEvt ? lpm_pkg::LPM_C_WDT :
                  (w.portEvt ? lpm_pkg::LPM_C_PORT : lpm_pkg::LPM_C_RTC);
            end
         end
         lpm_pkg::LPM_DEEP: begin
            if (w.portEvt || w.wdtEvt || w.rtcEvt || w.rstEvt) begin
               w.act = lpm_pkg::LPM_RESET;
               w.cause = lpm_pkg::LPM_C_RST;
            end
         end
         lpm_pkg::LPM_HOLD: begin
            if (w.rstEvt) begin
               w.act = lpm_pkg::LPM_RESET;
               w.cause = lpm_pkg::LPM_C_RST;
            end else if (w.wdtEvt) begin
               w.cause = lpm_pkg::LPM_C_WDT;
               w.act = w.wdtRstEn ? lpm_pkg::LPM_RESET :
                  (w.wdtIntEn ? lpm_pkg::LPM_ISR : lpm_pkg::LPM_RESUME);
            end else if (w.portEvt) begin
               w.cause = lpm_pkg::LPM_C_PORT;
               w.act = w.portIntEn ? lpm_pkg::LPM_ISR : lpm_pkg::LPM_RESUME;
            end else if (w.rtcEvt) begin
               w.cause = lpm_pkg::LPM_C_RTC;
               w.act = w.rtcIntEn ? lpm_pkg::LPM_ISR : lpm_pkg::LPM_RESUME;
            end
         end
         lpm_pkg::LPM_IDLE: begin
            if (w.rstEvt) begin
               w.act = lpm_pkg::LPM_RESET;
               w.cause = lpm_pkg::LPM_C_RST;
            end else if (w.irqEvt) begin
               w.cause = lpm_pkg::LPM_C_IRQ;
               w.act = w.globalIntEn ? lpm_pkg::LPM_ISR : lpm_pkg::LPM_RESUME;
            end
         end
         lpm_pkg::LPM_RUN: begin
            w.act = lpm_pkg::LPM_STAY;
         end
         default: begin
            w.act = lpm_pkg::LPM_RESET;
            w.cause = lpm_pkg::LPM_C_NONE;
         end
      endcase
   end
endmodule // lpm_wake_eval
`default_nettype wire

// ===== dv/lpm_core_model.sv
// Core, interrupt and wake sources around the power controller
// Assumes the bench calls fire at a rising edge of mclk
`timescale 1ns/1ps
`default_nettype none
module lpm_core_model (
   // Clock
   input wire logic mclk,
   // Wake and interrupt events
   output logic portWake,
   output logic rtcWake,
   output logic wdtWake,
   output logic resetEvent,
   output logic anyIrq,
   // Enables held by the core
   output logic portIntEn,
   output logic rtcIntEn,
   output logic wdtIntEn,
   output logic wdtResetEn,
   output logic globalIntEn
);
   // Quiet at time zero
   initial begin
      {resetEvent, wdtWake, portWake, rtcWake, anyIrq} = 5'h00;
      {portIntEn, rtcIntEn, wdtIntEn, wdtResetEn, globalIntEn} = 5'h00;
   end
   // Enables stay as levels, events last one cycle
   task automatic fire(input logic [4:0] ev, input logic [4:0] en);
      {portIntEn, rtcIntEn, wdtIntEn, wdtResetEn, globalIntEn} <= en;
      {resetEvent, wdtWake, portWake, rtcWake, anyIrq} <= ev;
      @(posedge mclk);
      {resetEvent, wdtWake, portWake, rtcWake, anyIrq} <= 5'h00;
   endtask
endmodule // lpm_core_model
`default_nettype wire

// ===== dv/lpm_ctrl_monitor.sv
// Checker of the power controller's mode and wake outputs
// Assumes it is bound onto lpm_ctrl and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_monitor (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Events and enables
   input wire logic portWake,
   input wire logic rtcWake,
   input wire logic wdtWake,
   input wire logic resetEvent,
   input wire logic anyIrq,
   input wire logic portIntEn,
   input wire logic wdtResetEn,
   input wire logic globalIntEn,
   // Clock gates
   input wire logic sysClkEn,
   input wire logic cpuClkEn,
   input wire logic clkSrcEn,
   input wire logic memCsEn,
   // Wake actions and mode
   input wire logic chipReset,
   input wire logic isrRequest,
   input wire logic [2:0] isrCause,
   input wire logic resumeNext,
   input wire logic [2:0] modeState
);
   // One clock domain, reset masks every check
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   // Mode checks
   AST_SLEEP_GATE: assert property (
      modeState == 3'h1 |-> !clkSrcEn && !memCsEn)
      else $error("sleep left clocks or selects on");
   AST_SLEEP_WAKE: assert property (
      modeState == 3'h1 && (portWake || rtcWake || wdtWake)
      |=> modeState == 3'h0 && chipReset)
      else $error("sleep wake did not reset");
   AST_SLEEP_STAY: assert property (
      modeState == 3'h1 && !portWake && !rtcWake && !wdtWake
      |=> modeState == 3'h1)
      else $error("sleep left without a wake");
   AST_HOLD_GATE: assert property (
      modeState == 3'h2 |-> !sysClkEn && clkSrcEn)
      else $error("hold clock gating wrong");
   AST_HOLD_STAY: assert property (
      modeState == 3'h2 && !(portWake || rtcWake || wdtWake || resetEvent)
      |=> modeState == 3'h2)
      else $error("hold left without a wake");
   AST_HOLD_ISR: assert property (
      modeState == 3'h2 && portWake && portIntEn && !wdtWake && !resetEvent
      |=> isrRequest && isrCause == 3'h1 ##1 !isrRequest)
      else $error("port wake from hold gave no service");
   AST_WDT_RST: assert property (
      modeState == 3'h2 && wdtWake && wdtResetEn
      |=> chipReset [*8] ##1 !chipReset)
      else $error("watchdog wake reset wrong");
   AST_IDLE_GATE: assert property (
      modeState == 3'h3 |-> sysClkEn && !cpuClkEn)
      else $error("idle clock gating wrong");
   AST_IDLE_EXIT: assert property (
      modeState == 3'h3 && anyIrq && !resetEvent
      |=> modeState == 3'h0 && isrRequest == $past(globalIntEn)
      && resumeNext != $past(globalIntEn))
      else $error("idle exit action wrong");
endmodule // lpm_ctrl_monitor
bind lpm_ctrl lpm_ctrl_monitor mon (.mclk, .srst, .portWake, .rtcWake,
   .wdtWake, .resetEvent, .anyIrq, .portIntEn, .wdtResetEn, .globalIntEn,
   .sysClkEn, .cpuClkEn, .clkSrcEn, .memCsEn, .chipReset, .isrRequest,
   .isrCause, .resumeNext, .modeState);
`default_nettype wire

// ===== dv/test_low_power_mode_control.sv
// Bench of the power controller: register access and mode walks
// Assumes lpm_core_model drives events and enables
`timescale 1ns/1ps
`default_nettype none
`include "lpm_consts.svh"
module test_low_power_mode_control;
   // Clock, reset and bus
   logic mclk = 1'h0, srst = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   // Events, enables and outputs
   logic portWake, rtcWake, wdtWake, resetEvent, anyIrq;
   logic portIntEn, rtcIntEn, wdtIntEn, wdtResetEn, globalIntEn;
   logic sysClkEn, cpuClkEn, clkSrcEn, memCsEn, decoderRamClkEn;
   logic internalRamClkEn, chipReset, isrRequest, resumeNext, deepSleep;
   logic batteryOutEn, sdPowerGateEn;
   logic [2:0] isrCause, modeState;
   int num_errors = 0, n_checks = 0;
   // Wake table: events, enables, {isr, resume, reset, cause}
   logic [4:0] tEv [10] = '{5'h04, 5'h04, 5'h02, 5'h02, 5'h08, 5'h08,
      5'h08, 5'h10, 5'h01, 5'h01};
   logic [4:0] tEn [10] = '{5'h10, 5'h00, 5'h08, 5'h00, 5'h06, 5'h04,
      5'h00, 5'h00, 5'h01, 5'h00};
   logic [5:0] tEx [10] = '{6'h21, 6'h11, 6'h22, 6'h12, 6'h0b, 6'h23,
      6'h13, 6'h0c, 6'h25, 6'h15};
   lpm_ctrl dut (.*);
   lpm_core_model partner (.*);
   // Free-running clock
   always #4 mclk = ~mclk;
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Verdict and end of run
   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Bus write: address and data offered together, response awaited
   task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
      int n;
      logic ha, hw, hb;
      n = 0;
      hb = 1'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!hb && n < 40) begin
         @(negedge mclk);
         ha = s_axi_awvalid && s_axi_awready;
         hw = s_axi_wvalid && s_axi_wready;
         hb = s_axi_bvalid;
         if (hb)
            chk("bresp", s_axi_bresp, er);
         @(posedge mclk);
         if (ha)
            s_axi_awvalid <= 1'h0;
         if (hw)
            s_axi_wvalid <= 1'h0;
         n++;
      end
      s_axi_bready <= 1'h0;
      if (!hb) begin
         num_errors++;
         conclude();
      end
   endtask
   // Bus read with expected data and response
   task automatic rd(input logic [7:0] a, ed, input logic [1:0] er);
      int n;
      logic ha, hr;
      n = 0;
      hr = 1'h0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!hr && n < 40) begin
         @(negedge mclk);
         ha = s_axi_arvalid && s_axi_arready;
         hr = s_axi_rvalid;
         if (hr) begin
            chk("rdata", s_axi_rdata, {24'h00_0000, ed});
            chk("rresp", s_axi_rresp, er);
         end
         @(posedge mclk);
         if (ha)
            s_axi_arvalid <= 1'h0;
         n++;
      end
      s_axi_rready <= 1'h0;
      if (!hr) begin
         num_errors++;
         conclude();
      end
   endtask
   // Request a mode and see it taken
   task automatic enter(input logic [7:0] v, input logic [2:0] m);
      wr(8'h00, v, `LPM_RESP_OK);
      @(posedge mclk);
      @(negedge mclk);
      chk("mode", modeState, m);
      @(posedge mclk);
   endtask
   // One event, then the action seen one cycle later
   task automatic wake(input logic [4:0] ev, en, input logic [5:0] ex);
      partner.fire(ev, en);
      @(negedge mclk);
      chk("wake", {isrRequest, resumeNext, chipReset, isrCause}, ex);
      chk("mode", modeState, 3'h0);
      repeat (10) @(posedge mclk);
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge mclk);
      srst <= 1'h0;
      @(posedge mclk);
      @(negedge mclk);
      chk("clocks", {sysClkEn, cpuClkEn, clkSrcEn, memCsEn,
         decoderRamClkEn, internalRamClkEn}, 6'h3f);
      @(posedge mclk);
      rd(8'h04, 8'h00, `LPM_RESP_OK);
      wr(8'h04, 8'h30, `LPM_RESP_OK);
      chk("power", {batteryOutEn, sdPowerGateEn}, 2'h3);
      wr(8'h04, 8'h10, `LPM_RESP_OK);
      chk("power", {batteryOutEn, sdPowerGateEn}, 2'h1);
      rd(8'h04, 8'h10, `LPM_RESP_OK);
      rd(8'h0c, 8'h00, `LPM_RESP_ERR);
      wr(8'h0c, 8'hff, `LPM_RESP_ERR);
      // Hold and idle wakes, each after an event the mode ignores
      for (int i = 0; i < 10; i++) begin
         enter(i < 8 ? 8'h02 : 8'h04, i < 8 ? 3'h2 : 3'h3);
         partner.fire(i < 8 ? 5'h01 : 5'h04, 5'h00);
         @(negedge mclk);
         chk("mode", modeState, i < 8 ? 3'h2 : 3'h3);
         @(posedge mclk);
         wake(tEv[i], tEn[i], tEx[i]);
         rd(8'h00, 8'h00, `LPM_RESP_OK);
      end
      // Sleep with the RAM clock disable bits written, which sleep entry clears, then deep sleep
      // Oscillator already selected and peripherals quiet here
      enter(8'h71, 3'h1);
      rd(8'h00, 8'h01, `LPM_RESP_OK);
      partner.fire(5'h10, 5'h00);
      @(negedge mclk);
      chk("mode", modeState, 3'h1);
      @(posedge mclk);
      wake(5'h08, 5'h00, 6'h0b);
      enter(8'h08, 3'h4);
      @(negedge mclk);
      chk("deep", deepSleep, 1'h1);
      @(posedge mclk);
      wake(5'h04, 5'h00, 6'h0c);
      conclude();
   end
endmodule // test_low_power_mode_control
`default_nettype wire
